// ### hdl/spk_packetizer.sv
// serial ingress packetizer with clear-to-send and radio egress serializer
// assumes the radio layer drives connect, beacon and transmit-done events
module spk_packetizer
   import spk_pkg::*;
#(
   parameter int unsigned TMO_DEFAULT = TMO_CYC,
   parameter int unsigned SLOW_PER    = SLOW_CYC,
   parameter int unsigned BLINK_PER   = BLINK_CYC,
   parameter int unsigned BIT_PER     = BIT_CYC
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   // serial pins
   input  wire logic        i_rxd,
   output logic             o_txd,
   output logic             o_cts,
   // configuration
   input  wire logic        i_gateway,
   input  wire logic [31:0] i_timeout_cyc,
   input  wire logic [1:0]  i_gw_policy,
   // radio side status
   input  wire logic        i_connected,
   input  wire logic        i_net_found,
   input  wire logic        i_beacon_sent,
   input  wire logic [1:0]  i_rssi_level,
   // packet out to radio
   output logic [7:0]       o_pkt_data,
   output logic             o_pkt_valid,
   output logic [6:0]       o_pkt_len,
   output logic             o_pkt_to_all,
   input  wire logic        i_pkt_read,
   input  wire logic        i_tx_done,
   // radio payload in
   input  wire logic [7:0]  i_rf_data,
   input  wire logic        i_rf_valid,
   input  wire logic        i_rf_crc_ok,
   output logic             o_rf_ready,
   // indicators and gateway policy
   output logic             o_signal_tx_indicator,
   output logic             o_link_rx_indicator,
   output logic             o_gw_refuse,
   output logic             o_gw_alert
);
   // shorter periods leave no room for the mid-bit sample and blink phases
   if (BIT_PER < 4 || SLOW_PER < 2 || BLINK_PER < 2 || TMO_DEFAULT == 0) begin : g_bad_param
      $error("spk: periods too short");
   end

   // receiver state
   spk_ser_t    rs_q, rs_d;
   logic [31:0] rc_q, rc_d;
   logic [2:0]  rb_q, rb_d;
   logic [7:0]  rsh_q, rsh_d;
   logic        rdone;
   // buffer and packet state
   logic [7:0]  mem_q [MAX_LEN];
   spk_pkt_t    ps_q, ps_d;
   logic [6:0]  cnt_q, cnt_d, rd_q, rd_d;
   logic [31:0] tmo_q, tmo_d;
   logic        cts_q, cts_d;
   // egress state
   spk_ser_t    ts_q, ts_d;
   logic [31:0] tc_q, tc_d;
   logic [2:0]  tb_q, tb_d;
   logic [7:0]  tsh_q, tsh_d;
   logic        txd_q, txd_d;
   // indicators
   logic [31:0] lc_q, lc_d;
   logic        sig_q, sig_d, lnk_q, lnk_d;

   // 8n1 receiver sampling mid-bit; framing error drops byte
   always_comb begin
      rs_d  = rs_q;
      rc_d  = rc_q;
      rb_d  = rb_q;
      rsh_d = rsh_q;
      rdone = 1'b0;
      case (rs_q)
         S_IDLE: if (!i_rxd) begin
            rs_d = S_START;
            rc_d = 32'(BIT_PER / 2);
         end
         S_START: if (rc_q == 32'h0) begin
            rs_d = i_rxd ? S_IDLE : S_DATA;
            rc_d = 32'(BIT_PER - 1);
            rb_d = 3'h0;
         end else rc_d = rc_q - 32'h1;
         S_DATA: if (rc_q == 32'h0) begin
            rsh_d = {i_rxd, rsh_q[7:1]};
            rc_d  = 32'(BIT_PER - 1);
            rb_d  = rb_q + 3'h1;
            if (rb_q == 3'h7) rs_d = S_STOP;
         end else rc_d = rc_q - 32'h1;
         S_STOP: if (rc_q == 32'h0) begin
            rs_d  = S_IDLE;
            rdone = i_rxd;
         end else rc_d = rc_q - 32'h1;
         default: rs_d = S_IDLE;
      endcase
   end

   // timeout from config input; zero means use default
   logic [31:0] tmo_lim;
   assign tmo_lim = (i_timeout_cyc == 32'h0) ? 32'(TMO_DEFAULT) : i_timeout_cyc;
   logic full, wr;
   assign full = (cnt_q == 7'(MAX_LEN));
   assign wr   = rdone && ps_q == P_FILL && !full;

   // fill, close and deliver packet
   always_comb begin
      ps_d  = ps_q;
      cnt_d = cnt_q;
      rd_d  = rd_q;
      tmo_d = tmo_q;
      cts_d = cts_q;
      case (ps_q)
         P_WAIT: if (i_connected && cnt_q == 7'h0) begin
            ps_d  = P_FILL;
            cts_d = 1'b0;
         end
         P_FILL: begin
            if (wr) begin
               cnt_d = cnt_q + 7'h1;
               tmo_d = 32'h0;
            end else if (cnt_q != 7'h0) tmo_d = tmo_q + 32'h1;
            if ((wr && cnt_q == 7'(MAX_LEN - 1)) || full) begin
               ps_d  = P_SEND;
               cts_d = 1'b1;
            end else if (!wr && cnt_q != 7'h0 && tmo_q >= tmo_lim - 32'h1) begin
               ps_d  = P_SEND;
               cts_d = 1'b1;
            end
         end
         P_SEND: begin
            tmo_d = 32'h0;
            if (i_pkt_read && rd_q != cnt_q) rd_d = rd_q + 7'h1;
            if (i_tx_done) begin
               cnt_d = 7'h0;
               rd_d  = 7'h0;
               ps_d  = i_connected ? P_FILL : P_WAIT;
               cts_d = !i_connected;
            end
         end
         default: ps_d = P_WAIT;
      endcase
   end

   // egress serializer, only checksum-good bytes
   always_comb begin
      ts_d  = ts_q;
      tc_d  = tc_q;
      tb_d  = tb_q;
      tsh_d = tsh_q;
      txd_d = txd_q;
      case (ts_q)
         S_IDLE: begin
            txd_d = 1'b1;
            if (i_rf_valid && i_rf_crc_ok) begin
               ts_d  = S_START;
               tsh_d = i_rf_data;
               tc_d  = 32'(BIT_PER - 1);
               txd_d = 1'b0;
            end
         end
         S_START, S_DATA: if (tc_q == 32'h0) begin
            tc_d = 32'(BIT_PER - 1);
            if (ts_q == S_DATA) tb_d = tb_q + 3'h1;
            else tb_d = 3'h0;
            if (ts_q == S_DATA && tb_q == 3'h7) begin
               ts_d  = S_STOP;
               txd_d = 1'b1;
            end else begin
               ts_d  = S_DATA;
               txd_d = (ts_q == S_START) ? tsh_q[0] : tsh_q[tb_q + 3'h1];
            end
         end else tc_d = tc_q - 32'h1;
         S_STOP: if (tc_q == 32'h0) ts_d = S_IDLE;
            else tc_d = tc_q - 32'h1;
         default: ts_d = S_IDLE;
      endcase
   end

   // indicators; slow blink while router is unconnected
   always_comb begin
      lc_d  = lc_q + 32'h1;
      sig_d = sig_q;
      lnk_d = lnk_q;
      if (i_gateway) begin
         lnk_d = 1'b0;
         if (i_beacon_sent) begin
            sig_d = 1'b1;
            lc_d  = 32'h0;
         end else if (lc_q >= 32'(BLINK_PER - 1)) sig_d = 1'b0;
      end else if (!i_connected) begin
         lnk_d = 1'b0;
         if (lc_q >= 32'(SLOW_PER - 1)) begin
            lc_d  = 32'h0;
            sig_d = !sig_q;
         end
      end else if (lc_q >= (32'(BLINK_PER) << (2'h3 - i_rssi_level))) begin
         lc_d  = 32'h0;
         sig_d = !sig_q;
         lnk_d = !lnk_q;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rs_q  <= S_IDLE;
         rc_q  <= 32'h0;
         rb_q  <= 3'h0;
         rsh_q <= 8'h0;
         ps_q  <= P_WAIT;
         cnt_q <= 7'h0;
         rd_q  <= 7'h0;
         tmo_q <= 32'h0;
         cts_q <= 1'b1;
         ts_q  <= S_IDLE;
         tc_q  <= 32'h0;
         tb_q  <= 3'h0;
         tsh_q <= 8'h0;
         txd_q <= 1'b1;
         lc_q  <= 32'h0;
         sig_q <= 1'b0;
         lnk_q <= 1'b0;
      end else begin
         rs_q  <= rs_d;
         rc_q  <= rc_d;
         rb_q  <= rb_d;
         rsh_q <= rsh_d;
         ps_q  <= ps_d;
         cnt_q <= cnt_d;
         rd_q  <= rd_d;
         tmo_q <= tmo_d;
         cts_q <= cts_d;
         ts_q  <= ts_d;
         tc_q  <= tc_d;
         tb_q  <= tb_d;
         tsh_q <= tsh_d;
         txd_q <= txd_d;
         lc_q  <= lc_d;
         sig_q <= sig_d;
         lnk_q <= lnk_d;
      end
   end

   // buffer array; no reset needed for payload storage
   always_ff @(posedge i_clock) begin
      if (wr) mem_q[cnt_q] <= rsh_q;
   end

   assign o_cts                 = cts_q;
   assign o_txd                 = txd_q;
   assign o_pkt_valid           = (ps_q == P_SEND) && (rd_q != cnt_q);
   assign o_pkt_data            = mem_q[(rd_q < 7'(MAX_LEN)) ? rd_q : 7'h0];
   assign o_pkt_len             = cnt_q;
   assign o_pkt_to_all          = i_gateway;
   assign o_rf_ready            = (ts_q == S_IDLE);
   assign o_signal_tx_indicator = sig_q;
   assign o_link_rx_indicator   = lnk_q;
   // existing network policy for gateways
   assign o_gw_refuse = i_gateway && i_net_found && i_gw_policy == GW_REFUSE;
   assign o_gw_alert  = i_gateway && i_net_found && i_gw_policy == GW_ALERT;

   // assertions
   property p_full_cts;
      @(posedge i_clock) disable iff (!i_nrst) full |-> o_cts;
   endproperty
   a_full_cts: assert property (p_full_cts) else $error("cts low with full buffer");
   property p_cts_conn;
      @(posedge i_clock) disable iff (!i_nrst) $fell(o_cts) |-> $past(i_connected);
   endproperty
   a_cts_conn: assert property (p_cts_conn) else $error("cts fell unconnected");
   property p_no_over;
      @(posedge i_clock) disable iff (!i_nrst) cnt_q <= 7'(MAX_LEN);
   endproperty
   a_no_over: assert property (p_no_over) else $error("buffer overfilled");
   property p_close;
      @(posedge i_clock) disable iff (!i_nrst)
         (ps_q == P_FILL && wr && cnt_q == 7'(MAX_LEN - 1)) |=> ps_q == P_SEND && o_cts;
   endproperty
   a_close: assert property (p_close) else $error("full packet not closed");
   property p_cts_hold;
      @(posedge i_clock) disable iff (!i_nrst)
         $rose(o_cts) |-> ($past(wr) && $past(cnt_q) == 7'(MAX_LEN - 1))
            || ($past(cnt_q) != 7'h0 && $past(tmo_q) >= $past(tmo_lim) - 32'h1);
   endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("cts rose without cause");
   property p_tx_idle;
      @(posedge i_clock) disable iff (!i_nrst) ts_q == S_IDLE |-> o_txd;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("txd low while idle");
   property p_bad_crc;
      @(posedge i_clock) disable iff (!i_nrst)
         (ts_q == S_IDLE && i_rf_valid && !i_rf_crc_ok) |=> ts_q == S_IDLE;
   endproperty
   a_bad_crc: assert property (p_bad_crc) else $error("bad payload sent");
   property p_tmo_reset;
      @(posedge i_clock) disable iff (!i_nrst) wr |=> tmo_q == 32'h0;
   endproperty
   a_tmo_reset: assert property (p_tmo_reset) else $error("timeout not restarted");
   property p_done;
      @(posedge i_clock) disable iff (!i_nrst)
         (ps_q == P_SEND && i_tx_done) |=> cnt_q == 7'h0;
   endproperty
   a_done: assert property (p_done) else $error("buffer not emptied");
   property p_tmo_close;
      @(posedge i_clock) disable iff (!i_nrst)
         (ps_q == P_FILL && !wr && cnt_q != 7'h0 && tmo_q >= tmo_lim - 32'h1)
            |=> ps_q == P_SEND && o_cts;
   endproperty
   a_tmo_close: assert property (p_tmo_close) else $error("timeout did not close packet");
   property p_cts_reopen;
      @(posedge i_clock) disable iff (!i_nrst)
         (ps_q == P_SEND && i_tx_done && i_connected) |=> !o_cts;
   endproperty
   a_cts_reopen: assert property (p_cts_reopen) else $error("cts not reopened");
   property p_gw_flash;
      @(posedge i_clock) disable iff (!i_nrst)
         (i_gateway && i_beacon_sent) |=> o_signal_tx_indicator;
   endproperty
   a_gw_flash: assert property (p_gw_flash) else $error("beacon not flashed");
   c_fill: cover property (@(posedge i_clock) ps_q == P_SEND && full);
   c_drop: cover property (@(posedge i_clock) rdone && !wr);
   c_tmo:  cover property (@(posedge i_clock) ps_q == P_FILL ##1 ps_q == P_SEND && !full);
   c_tx:   cover property (@(posedge i_clock) ts_q == S_STOP);
endmodule // spk_packetizer

// ### hdl/spk_pkg.sv
// constants and types for the serial packetizer with clear-to-send pacing
// assumes one 200 mhz clock and a host that keeps to the frame format
// How it works
// - serial port runs 19200 baud, 8 data bits, one stop, no parity.
// - up to 120 payload bytes from the receive pin are buffered.
// - packet closes and transmits when the buffer reaches 120 bytes.
// - packet closes when the idle timeout expires with data pending, default 20 ms.
// - the timeout value comes from a configuration input, not fixed logic.
// - clear-to-send is high while the receive buffer is full.
// - clear-to-send goes low only once connected and earlier data delivered.
// - once low, clear-to-send stays low until buffer full or timeout.
// - after successful transmit and emptied buffer, clear-to-send returns low while still connected.
// - a byte with valid framing is accepted only while filling and not full; host sends only while allowed.
// - radio payloads reach the transmit pin only when their checksum verifies.
// - gateway sends serial data to all routers, router sends to gateway.
// - gateway pulses the signal indicator once per presence beacon sent.
// - unconnected router flashes the signal indicator slowly.
// - connected router shows signal level and flashes the link indicator.
// - gateway meeting an existing network refuses, alerts or ignores per setting.
package spk_pkg;
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned BAUD          = 19200;
   localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
   localparam int unsigned HALF_CYC      = BIT_CYC / 2;
   localparam int unsigned DATA_BITS     = 8;
   localparam int unsigned MAX_LEN       = 120;
   localparam int unsigned TMO_MS        = 20;
   localparam int unsigned TMO_CYC       = CLK_HZ / 1000 * TMO_MS;
   localparam int unsigned SLOW_CYC      = CLK_HZ / 2;
   localparam int unsigned BLINK_CYC     = CLK_HZ / 20;
   localparam logic [1:0]  GW_REFUSE     = 2'h0;
   localparam logic [1:0]  GW_ALERT      = 2'h1;
   localparam logic [1:0]  GW_IGNORE     = 2'h2;
   typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} spk_ser_t;
   typedef enum logic [1:0] {P_WAIT, P_FILL, P_SEND} spk_pkt_t;
endpackage

// ### verification/spk_host_model.sv
// host model on the serial pins: sends framed bytes, receives bytes from txd
// assumes the bench calls send right after a rising clock edge
module spk_host_model
#(
   parameter int unsigned BIT_PER = 16
) (
   input  wire logic i_clock,
   input  wire logic i_cts,
   input  wire logic i_txd,
   output logic      o_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_byte;
   int         rx_cnt = 0;

   initial o_rxd = 1'b1;

   // obey low means a deliberate send while pacing says stop
   task automatic send(input logic [7:0] b, input logic obey);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      if (obey) begin
         while (i_cts !== 1'b0) @(posedge i_clock);
      end
      for (int i = 0; i < 10; i++) begin
         o_rxd <= fr[i];
         repeat (BIT_PER) @(posedge i_clock);
      end
   endtask

   // lsb first, counted only with a good stop bit
   always begin
      @(negedge i_txd);
      repeat (BIT_PER / 2) @(posedge i_clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_PER) @(posedge i_clock);
         rx_byte[i] = i_txd;
      end
      repeat (BIT_PER) @(posedge i_clock);
      if (i_txd === 1'b1) rx_cnt++;
   end
endmodule // spk_host_model

// ### verification/test_serial_packetizer_cts_flow.sv
// bench for the serial packetizer: pacing, packet close, egress, indicators
// assumes shortened counts: timeout 200, bit 16, slow 64, blink 8 cycles
module test_serial_packetizer_cts_flow;
   timeunit 1ns;
   timeprecision 1ps;
   import spk_pkg::*;
   localparam int unsigned T_BIT = 16;
   logic clk = 0, nrst = 0, gw = 0, conn = 0, nf = 0, bcn = 0, pread = 0, txdone = 0;
   logic rfv = 0, rfcrc = 0, rxd, txd, cts, rfrdy, sig, lnk, refuse, alert, pvalid, toall;
   logic [31:0] tmo = 0;
   logic [1:0]  pol = 0, rssi = 2'h3;
   logic [7:0]  pdata, rfd = 0;
   logic [6:0]  plen;
   int          err_count = 0, n_tests = 0, cyc = 0, hc;

   always #2.5 clk = ~clk;

   spk_packetizer #(.TMO_DEFAULT(200), .SLOW_PER(64), .BLINK_PER(8), .BIT_PER(T_BIT)) dut (
      .i_clock(clk), .i_nrst(nrst), .i_rxd(rxd), .o_txd(txd), .o_cts(cts),
      .i_gateway(gw), .i_timeout_cyc(tmo), .i_gw_policy(pol), .i_connected(conn),
      .i_net_found(nf), .i_beacon_sent(bcn), .i_rssi_level(rssi), .o_pkt_data(pdata),
      .o_pkt_valid(pvalid), .o_pkt_len(plen), .o_pkt_to_all(toall), .i_pkt_read(pread),
      .i_tx_done(txdone), .i_rf_data(rfd), .i_rf_valid(rfv), .i_rf_crc_ok(rfcrc),
      .o_rf_ready(rfrdy), .o_signal_tx_indicator(sig), .o_link_rx_indicator(lnk),
      .o_gw_refuse(refuse), .o_gw_alert(alert));

   spk_host_model #(.BIT_PER(T_BIT)) host (.i_clock(clk), .i_cts(cts), .i_txd(txd), .o_rxd(rxd));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic toggles(input string what, ref logic s, input int n);
      logic v;
      int   k;
      v = s;
      k = 0;
      while (s === v && k < n) begin
         tick(1);
         k++;
      end
      check(what, 1, k < n);
   endtask

   task automatic pulse_done;
      txdone <= 1'b1;
      tick(1);
      txdone <= 1'b0;
      tick(2);
   endtask

   // reads the whole packet and compares it against base + index
   task automatic drain(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         check("pkt_valid", 1, pvalid);
         check("pkt_byte", base + i[7:0], pdata);
         pread <= 1'b1;
         tick(1);
         pread <= 1'b0;
         tick(1);
      end
   endtask

   // bad crc bytes are never taken, so valid is dropped after one offer
   task automatic rf_send(input logic [7:0] d, input logic ok);
      int n;
      n = 0;
      rfd <= d;
      rfcrc <= ok;
      rfv <= 1'b1;
      do begin
         tick(1);
         n++;
      end while (rfrdy !== 1'b1 && n < 200);
      rfv <= 1'b0;
      tick(1);
      check("rf_busy", ok, !rfrdy);
      tick(12 * T_BIT - 1);
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         results();
      end
   end

   initial begin
      tick(5);
      check("cts_reset", 1, cts);
      nrst <= 1'b1;
      tick(5);
      toggles("slow_blink", sig, 200);
      check("cts_unconnected", 1, cts);
      conn <= 1'b1;
      tmo <= 32'd180;
      tick(300);
      check("cts_connected", 0, cts);
      toggles("link_blink", lnk, 40);
      $display("test connect done");
      for (int i = 0; i < 3; i++) host.send(8'ha0 + i[7:0], 1'b1);
      check("len3", 3, plen);
      tick(150);
      check("cts_before_tmo", 0, cts);
      tick(40);
      check("cts_after_tmo", 1, cts);
      drain(3, 8'ha0);
      check("cts_held", 1, cts);
      pulse_done();
      check("cts_after_done", 0, cts);
      check("len_cleared", 0, plen);
      $display("test timeout done");
      for (int i = 0; i < 121; i++) host.send(i[7:0], i < 120);
      check("len_full", 120, plen);
      check("cts_full", 1, cts);
      drain(120, 8'h00);
      pulse_done();
      check("cts_refill", 0, cts);
      $display("test full done");
      hc = host.rx_cnt;
      rf_send(8'h5a, 1'b1);
      check("txd_count", hc + 1, host.rx_cnt);
      check("txd_byte", 8'h5a, host.rx_byte);
      rf_send(8'hc3, 1'b0);
      check("txd_bad_crc", hc + 1, host.rx_cnt);
      $display("test egress done");
      check("to_all_router", 0, toall);
      gw <= 1'b1;
      nf <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         pol <= p[1:0];
         tick(2);
         check("gw_refuse", p == 0, refuse);
         check("gw_alert", p == 1, alert);
      end
      check("to_all_gateway", 1, toall);
      bcn <= 1'b1;
      tick(1);
      bcn <= 1'b0;
      tick(2);
      check("beacon_flash", 1, sig);
      tick(10);
      check("beacon_end", 0, sig);
      $display("test gateway done");
      results();
   end
endmodule // test_serial_packetizer_cts_flow
